// *** shared/pmd_pkg.sv ***
// Package for the peripheral module disable block: map, layouts and constants.
package pmd_pkg;

  // ==========================================================================
  // Register map (byte offsets within the block).
  // ==========================================================================
  localparam int PMD_ADDR_W = 8;
  localparam int PMD_GROUPS = 3;
  localparam logic [7:0] PMD_GROUP1_OFS = 8'h90;
  localparam logic [7:0] PMD_GROUP2_OFS = 8'ha0;
  localparam logic [7:0] PMD_GROUP3_OFS = 8'hb0;
  localparam logic [7:0] PMD_CFG0_OFS = 8'hc0;
  localparam int PMD_LOCK_BIT = 12;

  // Alias selector held in address bits 3:2.
  localparam logic [1:0] PMD_ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] PMD_ALIAS_CLEAR = 2'h1;
  localparam logic [1:0] PMD_ALIAS_SET = 2'h2;
  localparam logic [1:0] PMD_ALIAS_INVERT = 2'h3;

  // ==========================================================================
  // Implemented disable bits and reset values.
  // ==========================================================================
  localparam logic [31:0] PMD_GROUP1_MASK = 32'h2589_8991;
  localparam logic [31:0] PMD_GROUP2_MASK = 32'hf07f_0f0f;
  localparam logic [31:0] PMD_GROUP3_MASK = 32'h1903_1317;
  localparam logic [31:0] PMD_GROUP_RESET = 32'h0000_0000;
  localparam logic [31:0] PMD_CFG0_RESET = 32'h0000_0000;
  localparam logic [31:0] PMD_ZERO_WORD = 32'h0000_0000;

  // Selected bit positions, for peripheral-side wiring.
  localparam int PMD_ADC_SAR0_OFF = 0;
  localparam int PMD_DMA_OFF = 19;
  localparam int PMD_RANDOM_GEN_OFF = 26;
  localparam int PMD_QUAD_SPI_OFF = 29;
  localparam int PMD_TIMER1_OFF = 16;
  localparam int PMD_REFCLK_OUT1_OFF = 28;
  localparam int PMD_UART1_OFF = 0;
  localparam int PMD_WIRELESS_OFF = 12;
  localparam int PMD_CAN2_OFF = 28;

  // ==========================================================================
  // AHB-Lite encodings.
  // ==========================================================================
  localparam logic [1:0] PMD_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] PMD_HSIZE_WORD = 3'b010;
  localparam logic PMD_HRESP_OKAY = 1'b0;

  typedef logic [31:0] pmd_word_t;

  // Captured address phase, carried into the data phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [PMD_ADDR_W-1:0] addr;
  } pmd_dphase_t;

endpackage

// *** core/pmd_top.sv ***
// Peripheral module disable: AHB-Lite register file and per-module clock gates.
`timescale 1ns/1ps
module pmd_top
  import pmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [PMD_GROUPS*32-1:0] module_disable_bit,
  output logic disable_write_lock,
  output logic [PMD_GROUPS*32-1:0] periph_clk
);

  // ==========================================================================
  // Address phase capture.
  // ==========================================================================
  pmd_dphase_t dph_reg;
  pmd_dphase_t dph_next;
  logic take;

  assign take = hsel && hready && (htrans == PMD_HTRANS_NONSEQ);

  always_comb begin
    dph_next.valid = take;
    dph_next.write = hwrite;
    dph_next.word = (hsize == PMD_HSIZE_WORD);
    dph_next.addr = haddr[PMD_ADDR_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg <= '0;
    end else begin
      dph_reg <= dph_next;
    end
  end

  // ==========================================================================
  // Disable registers and lock.
  // ==========================================================================
  localparam logic [7:0] GROUP_OFS [PMD_GROUPS] = '{PMD_GROUP1_OFS, PMD_GROUP2_OFS, PMD_GROUP3_OFS};
  localparam logic [31:0] GROUP_MASK [PMD_GROUPS] = '{PMD_GROUP1_MASK, PMD_GROUP2_MASK, PMD_GROUP3_MASK};

  pmd_word_t group_reg [PMD_GROUPS];
  pmd_word_t group_next [PMD_GROUPS];
  pmd_word_t cfg0_reg;
  pmd_word_t cfg0_next;
  logic wr_ok;

  assign wr_ok = dph_reg.valid && dph_reg.write && dph_reg.word;

  // The lock register itself stays writable, so software can open the gate again.
  always_comb begin
    cfg0_next = cfg0_reg;
    if (wr_ok && (dph_reg.addr == PMD_CFG0_OFS)) begin
      cfg0_next = hwdata & (32'h0000_0001 << PMD_LOCK_BIT);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg0_reg <= PMD_CFG0_RESET;
    end else begin
      cfg0_reg <= cfg0_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PMD_GROUPS; g++) begin : g_group
      logic hit;
      pmd_word_t wval;

      assign hit = wr_ok && (dph_reg.addr[7:4] == GROUP_OFS[g][7:4]) && (dph_reg.addr[1:0] == 2'b00);
      assign wval = hwdata & GROUP_MASK[g];

      always_comb begin
        group_next[g] = group_reg[g];
        if (hit && !cfg0_reg[PMD_LOCK_BIT]) begin
          case (dph_reg.addr[3:2])
            PMD_ALIAS_PLAIN: group_next[g] = wval;
            PMD_ALIAS_CLEAR: group_next[g] = group_reg[g] & ~wval;
            PMD_ALIAS_SET: group_next[g] = group_reg[g] | wval;
            PMD_ALIAS_INVERT: group_next[g] = group_reg[g] ^ wval;
            default: group_next[g] = group_reg[g];
          endcase
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          group_reg[g] <= PMD_GROUP_RESET;
        end else begin
          group_reg[g] <= group_next[g];
        end
      end

      // Off flags double as the write block for the peripheral's own registers.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          module_disable_bit[g*32 +: 32] <= PMD_GROUP_RESET;
        end else begin
          module_disable_bit[g*32 +: 32] <= group_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disable_write_lock <= 1'b0;
    end else begin
      disable_write_lock <= cfg0_next[PMD_LOCK_BIT];
    end
  end

  // ==========================================================================
  // Read path.
  // ==========================================================================
  // Read data comes from next-state values so a read right after a write sees it.
  pmd_word_t rdata_next;
  logic [PMD_ADDR_W-1:0] raddr;

  assign raddr = haddr[PMD_ADDR_W-1:0];

  always_comb begin
    rdata_next = PMD_ZERO_WORD;
    if (take && !hwrite && (raddr[1:0] == 2'b00)) begin
      case (raddr[7:4])
        PMD_GROUP1_OFS[7:4]: rdata_next = group_next[0];
        PMD_GROUP2_OFS[7:4]: rdata_next = group_next[1];
        PMD_GROUP3_OFS[7:4]: rdata_next = group_next[2];
        PMD_CFG0_OFS[7:4]: rdata_next = (raddr[3:2] == 2'b00) ? cfg0_next : PMD_ZERO_WORD;
        default: rdata_next = PMD_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= PMD_ZERO_WORD;
    end else begin
      hrdata <= rdata_next;
    end
  end

  // Zero wait states: every transfer completes OKAY in one data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= PMD_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= PMD_HRESP_OKAY;
    end
  end

  // ==========================================================================
  // Clock gates.
  // ==========================================================================
  // The enable is latched while hclk is low, so it only changes when the gated
  // clock is already low and no pulse can be cut short. Software must switch the
  // module off before gating it; nothing here checks that.
  genvar b;
  generate
    for (b = 0; b < PMD_GROUPS*32; b++) begin : g_gate
      logic en_lat;

      always_latch begin
        if (!hclk) begin
          en_lat <= ~module_disable_bit[b];
        end
      end

      assign periph_clk[b] = hclk & en_lat;
    end
  endgenerate

endmodule // pmd_top

// *** tb/pmd_top_assertions.sv ***
// Port checker for the module disable block.
`timescale 1ns/1ps
module pmd_top_chk
  import pmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [95:0] module_disable_bit,
  input wire logic disable_write_lock,
  input wire logic [95:0] periph_clk
);
  localparam logic [95:0] M = {32'h1903_1317, 32'hf07f_0f0f, 32'h2589_8991};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr(logic [7:0] a);
    hsel && hready && htrans == PMD_HTRANS_NONSEQ && hwrite && hsize == PMD_HSIZE_WORD && haddr[7:0] == a
    ##1 !disable_write_lock;
  endsequence
  // ==========
  // Assertions
  // The gate latches during the low phase, so a high phase shows the bit of one half-cycle earlier.
  chk_gate_follow: assert property (@(negedge hclk) periph_clk == ~$past(module_disable_bit))
    else $error("gated clock wrong");
  chk_only_mapped: assert property ((module_disable_bit & ~M) == '0)
    else $error("unmapped disable bit set");
  chk_reset_zero: assert property ($rose(hresetn) |-> module_disable_bit == '0)
    else $error("disable bits not zero after reset");
  chk_lock_holds: assert property (disable_write_lock |=> $stable(module_disable_bit))
    else $error("disable bits changed under lock");
  chk_plain_wr: assert property (s_wr(8'h90) |=> module_disable_bit[31:0] == ($past(hwdata) & M[31:0]))
    else $error("plain write wrong");
  chk_clear_wr: assert property (s_wr(8'ha4) |=> module_disable_bit[63:32] ==
    ($past(module_disable_bit[63:32]) & ~($past(hwdata) & M[63:32]))) else $error("clear alias wrong");
  chk_set_wr: assert property (s_wr(8'hb8) |=> module_disable_bit[95:64] ==
    ($past(module_disable_bit[95:64]) | ($past(hwdata) & M[95:64]))) else $error("set alias wrong");
  chk_invert_wr: assert property (s_wr(8'h9c) |=> module_disable_bit[31:0] ==
    ($past(module_disable_bit[31:0]) ^ ($past(hwdata) & M[31:0]))) else $error("invert alias wrong");
endmodule // pmd_top_chk
bind pmd_top pmd_top_chk pmd_top_chk_i (.*);

// *** tb/pmd_periph_model.sv ***
// Peripheral stand-in that runs only from its gated clock.
`timescale 1ns/1ps
module pmd_periph_model (
  input wire logic pclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] ctrl_reg,
  output logic [15:0] edge_count
);
  // With its clock stopped nothing here moves, so writes are lost.
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_count <= 16'h0000;
      ctrl_reg <= 32'h0000_0000;
    end else begin
      edge_count <= edge_count + 16'h0001;
      if (wr_en) begin
        ctrl_reg <= wdata;
      end
    end
  end
endmodule // pmd_periph_model

// *** tb/pmd_top_bench.sv ***
// Self-checking bench for the module disable block.
`timescale 1ns/1ps
module pmd_top_bench;
  import pmd_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wr_en = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, wdata = 32'h0000_0000, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, lock;
  logic [31:0] hrdata, ctrl_reg;
  logic [95:0] mdb, pclk;
  logic [15:0] cnt, c0;
  int err_total = 0, check_count = 0;
  localparam logic [31:0] M [3] = '{32'h2589_8991, 32'hf07f_0f0f, 32'h1903_1317};
  localparam logic [7:0] B [3] = '{8'h90, 8'ha0, 8'hb0};
  pmd_top pmd_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .module_disable_bit(mdb), .disable_write_lock(lock), .periph_clk(pclk));
  pmd_periph_model pmd_periph_model_i (.pclk(pclk[19]), .rst_n(hresetn), .wr_en(wr_en), .wdata(wdata),
    .ctrl_reg(ctrl_reg), .edge_count(cnt));
  initial forever #20 hclk = ~hclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Called just after a rising edge; returns at the edge that ends the data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= PMD_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    check(q, e);
    check({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      rd(B[g], 32'h0000_0000);
      xfer(1'b1, B[g], 32'hffff_ffff);
      rd(B[g], M[g]);
      xfer(1'b1, B[g] + 8'h4, 32'hffff_ffff);
      rd(B[g], 32'h0000_0000);
      xfer(1'b1, B[g] + 8'h8, 32'h0000_ffff);
      rd(B[g], M[g] & 32'h0000_ffff);
      xfer(1'b1, B[g] + 8'hc, 32'hffff_ffff);
      rd(B[g], M[g] & 32'hffff_0000);
      check(mdb[g*32 +: 32], M[g] & 32'hffff_0000);
      xfer(1'b1, B[g], 32'h0000_0000);
    end
    rd(8'h40, 32'h0000_0000);
    $display("register test done");
    wr_en <= 1'b1;
    @(posedge hclk);
    wr_en <= 1'b0;
    xfer(1'b1, 8'h98, 32'h0008_0000);
    @(posedge hclk);
    c0 = cnt;
    wdata <= 32'h0000_00a5;
    wr_en <= 1'b1;
    repeat (8) @(posedge hclk);
    check({16'h0000, cnt - c0}, 32'h0000_0000);
    check(ctrl_reg, 32'h0000_0000);
    xfer(1'b1, 8'h94, 32'h0008_0000);
    repeat (3) @(posedge hclk);
    check(ctrl_reg, 32'h0000_00a5);
    $display("gating test done");
    xfer(1'b1, 8'hc0, 32'h0000_1000);
    @(posedge hclk);
    check({31'h0000_0000, lock}, 32'h0000_0001);
    xfer(1'b1, 8'h90, 32'hffff_ffff);
    xfer(1'b1, 8'hb8, 32'hffff_ffff);
    rd(8'h90, 32'h0000_0000);
    rd(8'hb0, 32'h0000_0000);
    xfer(1'b1, 8'hc0, 32'h0000_0000);
    xfer(1'b1, 8'hb0, 32'h0800_0000);
    rd(8'hb0, 32'h0800_0000);
    $display("lock test done");
    xfer(1'b1, 8'h90, 32'hffff_ffff);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h90, 32'h0000_0000);
    rd(8'hb0, 32'h0000_0000);
    $display("reset test done");
    print_verdict();
  end
endmodule // pmd_top_bench
